// file: rtl/mdsf_pkg.sv
package mdsf_pkg;
    localparam logic [6:0] MOTOR1_DIAG_ADDR = 7'h6F;
    localparam logic [6:0] MOTOR2_DIAG_ADDR = 7'h7F;
    localparam int STANDSTILL_BIT = 31;
    localparam int OPENLOAD_B_BIT = 30;
    localparam int OPENLOAD_A_BIT = 29;
    localparam int SHORT_B_BIT    = 28;
    localparam int SHORT_A_BIT    = 27;
    localparam int PREWARN_BIT    = 26;
    localparam int SHUTDOWN_BIT   = 25;
    localparam int STALL_BIT      = 24;
    localparam int SCALE_MSB      = 20;
    localparam int SCALE_BITS     = 5;
    localparam int LOAD_LSB       = 0;
    localparam int LOAD_BITS      = 10;
    localparam logic [31:0] DIAG_RESET = 32'h0000_0000;
    localparam logic [1:0] SHORT_RESET = 2'h0;
    localparam int SYNC_STAGES    = 2;
endpackage

// file: rtl/mdsf_sync_if.sv
`timescale 1ns/10ps
interface mdsf_sync_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] rawLevel;
    logic [WIDTH-1:0] syncLevel;
    modport owner (output rawLevel, input syncLevel);
    modport sync  (input rawLevel, output syncLevel);
endinterface

// file: rtl/mdsf_sync.sv
`timescale 1ns/10ps
module mdsf_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic core_clk,
    input  wire logic reset_n,
    mdsf_sync_if.sync bus
);
    import mdsf_pkg::*;

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end
        else
        begin
            stage1_reg <= bus.rawLevel;
            stage2_reg <= stage1_reg;
        end
    end

    assign bus.syncLevel = stage2_reg;
endmodule

// file: rtl/mdsf_motor_driver_status_flags.sv
// Behaviour
// - two diagnostic words, one per motor, at addresses 6F and 7F
// - bit 31 shows motor standstill in every mode
// - bit 30 open load phase B, bit 29 open load phase A
// - open load flags are informative; no protective action taken
// - bits 28/27 show ground shorts on B/A; short disables that driver
// - short flags stay latched until off-time zero or disable input
// - bit 26 shows overtemperature pre-warning threshold exceeded
// - one shared pre-warning appears in both words
// - bit 25 shutdown; drivers stay off until pre-warning clears
// - shared shutdown condition appears in both words
// - bit 24 stall when load value is zero or constant-drive stall
// - field from bit 20 shows actual current scaling
// - stall compares load measurement against zero
// - low field carries load measurement; larger means lower load
`timescale 1ns/10ps
module mdsf_motor_driver_status_flags #(
    parameter int SCALE_W = mdsf_pkg::SCALE_BITS,
    parameter int LOAD_W  = mdsf_pkg::LOAD_BITS
) (
    input  wire logic               core_clk,
    input  wire logic               reset_n,
    input  wire logic [6:0]         readAddr,
    output logic      [31:0]        readData,
    input  wire logic [1:0]         standstill,
    input  wire logic [1:0]         openLoadA,
    input  wire logic [1:0]         openLoadB,
    input  wire logic [1:0]         ground_short_phase_a,
    input  wire logic [1:0]         ground_short_phase_b,
    input  wire logic               thermalPrewarn,
    input  wire logic               thermalLimit,
    input  wire logic [1:0]         constDriveStall,
    input  wire logic [2*SCALE_W-1:0] currentScale,
    input  wire logic [2*LOAD_W-1:0]  load_measure_value,
    input  wire logic [1:0]         offtimeZero,
    input  wire logic               driver_disable_input,
    output logic      [1:0]         driverEnable,
    output logic                    thermal_shutdown_flag
);
    import mdsf_pkg::*;

    if (SCALE_W < 1 || SCALE_W > SCALE_BITS || LOAD_W < 1 || LOAD_W > LOAD_BITS)
    begin : g_width_check
        $error("unsupported field width");
    end

    if (SCALE_MSB - SCALE_W < LOAD_LSB + LOAD_W - 1)
    begin : g_overlap_check
        $error("scale field overlaps load field");
    end

    // two-stage sync of pin inputs
    localparam int NSYNC = 13;
    mdsf_sync_if #(.WIDTH(NSYNC)) pinSync ();
    mdsf_sync #(.WIDTH(NSYNC)) pinSyncInst (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .bus      (pinSync.sync)
    );

    assign pinSync.rawLevel = {
        driver_disable_input,
        thermalLimit,
        thermalPrewarn,
        ground_short_phase_b,
        ground_short_phase_a,
        openLoadB,
        openLoadA,
        standstill
    };

    wire logic [1:0] stillS   = pinSync.syncLevel[1:0];
    wire logic [1:0] olaS     = pinSync.syncLevel[3:2];
    wire logic [1:0] olbS     = pinSync.syncLevel[5:4];
    wire logic [1:0] shortAS  = pinSync.syncLevel[7:6];
    wire logic [1:0] shortBS  = pinSync.syncLevel[9:8];
    wire logic       prewarnS = pinSync.syncLevel[10];
    wire logic       limitS   = pinSync.syncLevel[11];
    wire logic       disableS = pinSync.syncLevel[12];

    logic [1:0] shortA_reg;
    logic [1:0] shortB_reg;
    logic [1:0] shortA_next;
    logic [1:0] shortB_next;
    logic       shutdown_reg;
    logic       shutdown_next;
    logic [31:0] readData_reg;
    logic [31:0] readData_next;
    logic [1:0]  driverEnable_reg;
    logic [1:0]  driverEnable_next;

    wire logic [1:0] shortClear = offtimeZero | {2{disableS}};

    assign shortA_next = shortAS | (shortA_reg & ~shortClear);
    assign shortB_next = shortBS | (shortB_reg & ~shortClear);

    assign shutdown_next = limitS | (shutdown_reg & prewarnS);

    wire logic [1:0] shortAny   = shortA_next | shortB_next;
    wire logic [1:0] thermalOff = {2{shutdown_next}};
    assign driverEnable_next = ~(shortAny | thermalOff | shortClear);

    logic [31:0] word [2];
    genvar m;
    generate
        for (m = 0; m < 2; m++)
        begin : g_word
            wire logic [LOAD_W-1:0]  loadM  = load_measure_value[m*LOAD_W +: LOAD_W];
            wire logic [SCALE_W-1:0] scaleM = currentScale[m*SCALE_W +: SCALE_W];
            wire logic loadZero = (loadM == '0);
            wire logic stall_detect_flag = loadZero | constDriveStall[m];
            always_comb
            begin
                word[m] = DIAG_RESET;
                word[m][STANDSTILL_BIT] = stillS[m];
                word[m][OPENLOAD_B_BIT] = olbS[m];
                word[m][OPENLOAD_A_BIT] = olaS[m];
                word[m][SHORT_B_BIT] = shortB_reg[m];
                word[m][SHORT_A_BIT] = shortA_reg[m];
                word[m][PREWARN_BIT] = prewarnS;
                word[m][SHUTDOWN_BIT] = shutdown_reg;
                word[m][STALL_BIT] = stall_detect_flag;
                word[m][SCALE_MSB -: SCALE_W] = scaleM;
                word[m][LOAD_LSB +: LOAD_W] = loadM;
            end
        end
    endgenerate

    wire logic hit1 = (readAddr == MOTOR1_DIAG_ADDR);
    wire logic hit2 = (readAddr == MOTOR2_DIAG_ADDR);
    wire logic [31:0] motor1Sel = hit1 ? word[0] : DIAG_RESET;
    wire logic [31:0] motor2Sel = hit2 ? word[1] : DIAG_RESET;
    assign readData_next = motor1Sel | motor2Sel;

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            shortA_reg <= SHORT_RESET;
        end
        else
        begin
            shortA_reg <= shortA_next;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            shortB_reg <= SHORT_RESET;
        end
        else
        begin
            shortB_reg <= shortB_next;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            shutdown_reg <= 1'h0;
        end
        else
        begin
            shutdown_reg <= shutdown_next;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            readData_reg <= DIAG_RESET;
        end
        else
        begin
            readData_reg <= readData_next;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            driverEnable_reg <= 2'h0;
        end
        else
        begin
            driverEnable_reg <= driverEnable_next;
        end
    end

    assign readData              = readData_reg;
    assign driverEnable          = driverEnable_reg;
    assign thermal_shutdown_flag = shutdown_reg;
endmodule

// file: verification/mdsf_props.sv
`timescale 1ns/10ps
module mdsf_props #(
    parameter int SCALE_W = 5,
    parameter int LOAD_W  = 10
) (
    input wire logic                  core_clk,
    input wire logic                  reset_n,
    input wire logic [6:0]            readAddr,
    input wire logic [31:0]           readData,
    input wire logic [1:0]            ground_short_phase_a,
    input wire logic                  thermalPrewarn,
    input wire logic                  thermalLimit,
    input wire logic [2*SCALE_W-1:0]  currentScale,
    input wire logic [2*LOAD_W-1:0]   load_measure_value,
    input wire logic [1:0]            driverEnable,
    input wire logic                  thermal_shutdown_flag
);
default clocking @(posedge core_clk); endclocking
default disable iff (!reset_n);
a_unmapped_zero: assert property (readAddr != 7'h6F && readAddr != 7'h7F |=> readData == 32'h0)
    else $error("unmapped read not zero");
a_reserved_zero: assert property (readData[23:21] == 3'h0 && readData[15:10] == 6'h00)
    else $error("reserved bits set");
a_load_field: assert property (readAddr == 7'h6F |=> readData[9:0] == $past(load_measure_value[9:0]))
    else $error("load field wrong");
a_scale_field: assert property (readAddr == 7'h7F |=> readData[20-:SCALE_W] == $past(currentScale[SCALE_W+:SCALE_W]))
    else $error("scale field wrong");
a_stall_zero: assert property (readAddr == 7'h7F && load_measure_value[19:10] == 10'h000 |=> readData[24])
    else $error("stall not shown");
a_short_disable: assert property (ground_short_phase_a[0] [*6] |-> !driverEnable[0])
    else $error("short did not disable");
a_therm_off: assert property (thermalLimit [*6] |-> driverEnable == 2'h0 && thermal_shutdown_flag)
    else $error("overtemp did not disable");
a_therm_hold: assert property (thermalPrewarn [*3] ##0 thermal_shutdown_flag |=> thermal_shutdown_flag)
    else $error("shutdown released while warm");
endmodule
bind mdsf_motor_driver_status_flags mdsf_props #(.SCALE_W(SCALE_W), .LOAD_W(LOAD_W)) i_props (.core_clk, .reset_n,
    .readAddr, .readData, .ground_short_phase_a, .thermalPrewarn, .thermalLimit, .currentScale, .load_measure_value,
    .driverEnable, .thermal_shutdown_flag);

// file: verification/mdsf_host.sv
`timescale 1ns/10ps
module mdsf_host (
    input  wire logic        core_clk,
    output logic      [6:0]  readAddr,
    input  wire logic [31:0] readData
);
initial readAddr = 7'h00;
task automatic readWord(input logic [6:0] addr, output logic [31:0] data);
    @(negedge core_clk);
    readAddr = addr;
    @(negedge core_clk);
    data = readData;
    readAddr = 7'h00;
endtask
endmodule

// file: verification/mdsf_motor_driver_status_flags_bench.sv
`timescale 1ns/10ps
module mdsf_motor_driver_status_flags_bench;
logic core_clk = 0, reset_n = 0, thermalPrewarn = 0, thermalLimit = 0, driver_disable_input = 0;
logic [1:0] standstill = 0, openLoadA = 0, openLoadB = 0, ground_short_phase_a = 0, ground_short_phase_b = 0;
logic [1:0] constDriveStall = 0, offtimeZero = 0, driverEnable;
logic [9:0] currentScale = 0;
logic [19:0] load_measure_value = 20'h00101;
logic [6:0] readAddr;
logic [31:0] readData, w;
logic thermal_shutdown_flag;
int err_count = 0, checked = 0;
mdsf_motor_driver_status_flags i_dut (.core_clk, .reset_n, .readAddr, .readData, .standstill,
    .openLoadA, .openLoadB, .ground_short_phase_a, .ground_short_phase_b, .thermalPrewarn, .thermalLimit,
    .constDriveStall, .currentScale, .load_measure_value, .offtimeZero, .driver_disable_input, .driverEnable,
    .thermal_shutdown_flag);
mdsf_host i_host (.core_clk, .readAddr, .readData);
initial forever #10 core_clk = ~core_clk;
task automatic summarize;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
        err_count++;
        $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
    end
endtask
task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
endtask
task automatic rd(input logic [6:0] a, input logic [31:0] exp);
    i_host.readWord(a, w);
    chk(exp, w);
endtask
task automatic t_word;
    // open load read with one motor moving, one stopped
    standstill = 2'b10;
    openLoadA = 2'b01;
    openLoadB = 2'b10;
    load_measure_value = 20'h003FF;
    currentScale = 10'h155;
    idle(5);
    rd(7'h6F, 32'h2015_03FF);
    rd(7'h7F, 32'hC10A_0000);
    rd(7'h70, 32'h0);
    chk(32'h3, {30'h0, driverEnable});
    constDriveStall = 2'b01;
    rd(7'h6F, 32'h2115_03FF);
    standstill = 0;
    openLoadA = 0;
    openLoadB = 0;
    constDriveStall = 0;
    load_measure_value = 20'h00401;
    currentScale = 0;
    idle(5);
endtask
task automatic t_short;
    ground_short_phase_a = 2'b01;
    ground_short_phase_b = 2'b10;
    idle(7);
    ground_short_phase_a = 0;
    ground_short_phase_b = 0;
    idle(4);
    rd(7'h6F, 32'h0800_0001);
    rd(7'h7F, 32'h1000_0001);
    chk(32'h0, {30'h0, driverEnable});
    offtimeZero = 2'b01;
    idle(2);
    offtimeZero = 0;
    idle(3);
    rd(7'h6F, 32'h0000_0001);
    rd(7'h7F, 32'h1000_0001);
    chk(32'h1, {30'h0, driverEnable});
    driver_disable_input = 1;
    idle(4);
    driver_disable_input = 0;
    idle(5);
    rd(7'h7F, 32'h0000_0001);
    chk(32'h3, {30'h0, driverEnable});
endtask
task automatic t_therm;
    thermalPrewarn = 1;
    idle(5);
    rd(7'h6F, 32'h0400_0001);
    rd(7'h7F, 32'h0400_0001);
    chk(32'h3, {30'h0, driverEnable});
    thermalLimit = 1;
    idle(6);
    rd(7'h6F, 32'h0600_0001);
    rd(7'h7F, 32'h0600_0001);
    thermalLimit = 0;
    idle(6);
    rd(7'h7F, 32'h0600_0001);
    chk(32'h0, {30'h0, driverEnable});
    chk(32'h1, {31'h0, thermal_shutdown_flag});
    thermalPrewarn = 0;
    idle(6);
    rd(7'h6F, 32'h0000_0001);
    chk(32'h3, {30'h0, driverEnable});
    chk(32'h0, {31'h0, thermal_shutdown_flag});
endtask
initial
begin
    #200000;
    err_count++;
    summarize();
end
initial
begin
    idle(12);
    reset_n = 1;
    idle(3);
    t_word();
    t_short();
    t_therm();
    summarize();
end
endmodule
